// >>> hdl/rldc_ladder_decode.sv
// Combinational decode of the ladder fields into switch controls.
// Assumes its inputs come from registers; the caller registers outputs.
`timescale 1ns/1ns
`default_nettype none
module rldc_ladder_decode
  import rldc_pkg::*;
#(
  parameter int LEVELS = RLDC_LEVELS,
  parameter int CODE_W = RLDC_CODE_W
)
(
  input wire logic converter_on, // Ladder powered
  input wire logic low_power_polarity, // Clamp polarity
  input wire logic [1:0] positive_source_select, // Source code
  input wire logic [CODE_W-1:0] level_code, // Tap code
  output logic [LEVELS-1:0] tap_select, // One-hot tap
  output logic clamp_pos, // Output tied to top
  output logic clamp_neg, // Output tied to bottom
  output logic pos_connect, // Top end switch closed
  output logic neg_connect, // Bottom end switch closed
  output logic [2:0] source_select // One-hot source
);

  // ==========================================================
  // Elaboration check
  // The tap decoder needs exactly one tap per code
  if (LEVELS != (2 ** CODE_W))
  begin : g_bad_levels
    $error("LEVELS must equal two to the power CODE_W");
  end

  // ==========================================================
  // Tap decode: each code picks one tap, only while powered
  for (genvar i = 0; i < LEVELS; i++)
  begin : g_tap
    assign tap_select[i] = converter_on &&
      (level_code == CODE_W'(i));
  end

  // ==========================================================
  // Low-power clamps and end-switch control
  // Off state keeps just one end connected, so no ladder current flows
  assign clamp_pos = !converter_on && low_power_polarity &&
    (level_code == RLDC_CODE_ONES);
  assign clamp_neg = !converter_on && !low_power_polarity &&
    (level_code == RLDC_CODE_ZEROS);
  assign neg_connect = converter_on || !low_power_polarity;
  assign pos_connect = converter_on || low_power_polarity;

  // ==========================================================
  // Positive source: reserved code closes no switch at all
  assign source_select =
    (positive_source_select == RLDC_PSS_SUPPLY) ? RLDC_SRC_SUPPLY :
    (positive_source_select == RLDC_PSS_EXTREF) ? RLDC_SRC_EXTREF :
    (positive_source_select == RLDC_PSS_FIXED) ? RLDC_SRC_FIXED :
    RLDC_SRC_NONE;

endmodule
`default_nettype wire

// >>> hdl/rldc_pkg.sv
// Shared constants for the resistor-ladder reference control block.
// Assumes a 32-bit AHB-Lite slave window chosen by the fabric's hsel.
package rldc_pkg;

  // ==========================================================
  // Register map (byte addresses within the slave window)
  localparam logic [3:0] RLDC_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] RLDC_LEVEL_OFFSET = 4'h4;
  localparam int RLDC_ADDR_LSB = 0;
  localparam int RLDC_ADDR_MSB = 3;

  // ==========================================================
  // Field positions of the control register
  localparam int RLDC_ON_BIT = 7;
  localparam int RLDC_LPP_BIT = 6;
  localparam int RLDC_PDE_BIT = 5;
  localparam int RLDC_PSS_LSB = 2;
  localparam int RLDC_PSS_MSB = 3;

  // ==========================================================
  // Field positions of the level register
  localparam int RLDC_CODE_LSB = 0;
  localparam int RLDC_CODE_MSB = 4;

  // ==========================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RLDC_CTRL_RESET = 8'h00;
  localparam logic [7:0] RLDC_LEVEL_RESET = 8'h00;
  localparam logic [7:0] RLDC_CTRL_WMASK = 8'hec;
  localparam logic [7:0] RLDC_LEVEL_WMASK = 8'h1f;

  // ==========================================================
  // Ladder geometry and codes
  localparam int RLDC_LEVELS = 32;
  localparam int RLDC_CODE_W = 5;
  localparam logic [4:0] RLDC_CODE_ONES = 5'h1f;
  localparam logic [4:0] RLDC_CODE_ZEROS = 5'h00;

  // ==========================================================
  // Positive source select codes and one-hot switch patterns
  localparam logic [1:0] RLDC_PSS_SUPPLY = 2'h0;
  localparam logic [1:0] RLDC_PSS_EXTREF = 2'h1;
  localparam logic [1:0] RLDC_PSS_FIXED = 2'h2;
  localparam logic [1:0] RLDC_PSS_RSVD = 2'h3;
  localparam logic [2:0] RLDC_SRC_SUPPLY = 3'h1;
  localparam logic [2:0] RLDC_SRC_EXTREF = 3'h2;
  localparam logic [2:0] RLDC_SRC_FIXED = 3'h4;
  localparam logic [2:0] RLDC_SRC_NONE = 3'h0;

  // ==========================================================
  // Bus values
  localparam logic [31:0] RLDC_RDATA_RESET = 32'h0000_0000;

endpackage

// >>> hdl/rldc_top.sv
// Resistor-ladder reference control: AHB-Lite registers and switch drive.
// Assumes one clock hclk, an AHB-Lite master and an analog ladder that
// follows the registered switch controls; the pin level is asynchronous.
//
// Operation
// - Ladder is powered only while converter_on is set.
// - Thirty-two levels, one ladder tap per five-bit level_code.
// - Enabled output is bottom source plus span times code over 32.
// - Off, polarity one, code all ones: clamp to top, bottom open.
// - Off, polarity zero, code all zeros: clamp to bottom, top open.
// - Off, polarity one opens bottom source; polarity zero opens top source.
// - Source code 00 supply, 01 external reference, 10 fixed buffer.
// - Pin drive enable routes output to pin, kills digital driver, detector.
// - Digital read of the pin returns zero while it carries output.
// - Wake from sleep leaves the control register untouched.
// - Reset disables ladder, frees the pin and clears level_code.
// - Control: on bit 7, polarity 6, pin enable 5, source 3-2.
// - Level register: code in bits 4-0, bits 7-5 read zero.
// - Control bits 4, 1, 0 read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module rldc_top
  import rldc_pkg::*;
(
  input wire logic hclk, // System clock, 50 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic wake_event, // Wake from sleep pulse
  input wire logic pin_level, // Raw digital level of the pin
  output logic ladder_power, // Ladder bias on
  output logic [RLDC_LEVELS-1:0] tap_select, // One-hot tap
  output logic clamp_pos, // Output tied to top source
  output logic clamp_neg, // Output tied to bottom source
  output logic pos_connect, // Top source switch closed
  output logic neg_connect, // Bottom source switch closed
  output logic [2:0] source_select, // One-hot positive source
  output logic pin_route_analog, // Output switched to pin
  output logic pin_driver_off, // Digital driver forced off
  output logic pin_detector_off, // Input detector forced off
  output logic pin_read_value // Digital read of the pin
);

  // ==========================================================
  // Register storage
  logic [7:0] ref_ladder_control;
  logic [7:0] ref_ladder_level;

  // Data-phase state captured from the address phase
  logic dp_wr_ctrl;
  logic dp_wr_level;

  // Pin synchroniser
  logic pin_meta;
  logic pin_sync;

  // ==========================================================
  // Address phase decode
  wire addr_take = hsel && htrans[1] && hready;
  wire [3:0] addr_low = haddr[RLDC_ADDR_MSB:RLDC_ADDR_LSB];
  wire hit_ctrl = addr_take && (addr_low == RLDC_CTRL_OFFSET);
  wire hit_level = addr_take && (addr_low == RLDC_LEVEL_OFFSET);
  wire take_read = addr_take && !hwrite;
  wire next_dp_wr_ctrl = hit_ctrl && hwrite;
  wire next_dp_wr_level = hit_level && hwrite;

  // ==========================================================
  // Register next values
  // Masks keep unimplemented bits at zero whatever software writes
  wire [7:0] next_control = dp_wr_ctrl ?
    (hwdata[7:0] & RLDC_CTRL_WMASK) : ref_ladder_control;
  wire [7:0] next_level = dp_wr_level ?
    (hwdata[7:0] & RLDC_LEVEL_WMASK) : ref_ladder_level;

  // ==========================================================
  // Read mux
  // Reads use next values so a read right after a write sees it;
  // unmapped offsets read zero and still answer OKAY
  wire [31:0] rd_ctrl = {24'h00_0000, next_control};
  wire [31:0] rd_level = {24'h00_0000, next_level};
  wire [31:0] next_hrdata = !take_read ? RLDC_RDATA_RESET :
    hit_ctrl ? rd_ctrl :
    hit_level ? rd_level : RLDC_RDATA_RESET;

  // ==========================================================
  // Field extraction
  wire f_on = ref_ladder_control[RLDC_ON_BIT];
  wire f_lpp = ref_ladder_control[RLDC_LPP_BIT];
  wire f_pde = ref_ladder_control[RLDC_PDE_BIT];
  wire [1:0] f_pss = ref_ladder_control[RLDC_PSS_MSB:RLDC_PSS_LSB];
  wire [RLDC_CODE_W-1:0] f_code =
    ref_ladder_level[RLDC_CODE_MSB:RLDC_CODE_LSB];

  // ==========================================================
  // Ladder decode
  wire [RLDC_LEVELS-1:0] next_tap_select;
  wire next_clamp_pos;
  wire next_clamp_neg;
  wire next_pos_connect;
  wire next_neg_connect;
  wire [2:0] next_source_select;

  rldc_ladder_decode #(
    .LEVELS(RLDC_LEVELS),
    .CODE_W(RLDC_CODE_W)
  ) u_decode (
    .converter_on(f_on),
    .low_power_polarity(f_lpp),
    .positive_source_select(f_pss),
    .level_code(f_code),
    .tap_select(next_tap_select),
    .clamp_pos(next_clamp_pos),
    .clamp_neg(next_clamp_neg),
    .pos_connect(next_pos_connect),
    .neg_connect(next_neg_connect),
    .source_select(next_source_select)
  );

  // Digital read is blanked while the pin carries the analog level
  wire next_pin_read = pin_sync && !f_pde;

  // ==========================================================
  // Bus handshake flops
  // Zero wait states, so hreadyout simply stays high after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= RLDC_RDATA_RESET;
      dp_wr_ctrl <= 1'b0;
      dp_wr_level <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      dp_wr_ctrl <= next_dp_wr_ctrl;
      dp_wr_level <= next_dp_wr_level;
    end
  end

  // ==========================================================
  // Control registers
  // Only a bus write changes them; wake_event has no path here, so
  // the control contents survive a wake from sleep
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_ladder_control <= RLDC_CTRL_RESET;
      ref_ladder_level <= RLDC_LEVEL_RESET;
    end
    else
    begin
      ref_ladder_control <= next_control;
      ref_ladder_level <= next_level;
    end
  end

  // ==========================================================
  // Pin level synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= pin_level;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // Output flops
  // Registered so the analog switches never see decode glitches;
  // the cost is one extra cycle from register to switch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ladder_power <= 1'b0;
      tap_select <= '0;
      clamp_pos <= 1'b0;
      clamp_neg <= 1'b0;
      pos_connect <= 1'b0;
      neg_connect <= 1'b0;
      source_select <= RLDC_SRC_NONE;
      pin_route_analog <= 1'b0;
      pin_driver_off <= 1'b0;
      pin_detector_off <= 1'b0;
      pin_read_value <= 1'b0;
    end
    else
    begin
      ladder_power <= f_on;
      tap_select <= next_tap_select;
      clamp_pos <= next_clamp_pos;
      clamp_neg <= next_clamp_neg;
      pos_connect <= next_pos_connect;
      neg_connect <= next_neg_connect;
      source_select <= next_source_select;
      pin_route_analog <= f_pde;
      pin_driver_off <= f_pde;
      pin_detector_off <= f_pde;
      pin_read_value <= next_pin_read;
    end
  end

  // ==========================================================
  // Assertions
  // Checks arm one edge after reset release: an attempt that starts on
  // the releasing edge would otherwise see reset-valued outputs as wrong
  logic chk_armed;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chk_armed <= 1'b0;
    else
      chk_armed <= 1'b1;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !chk_armed);

  wire wd_on = hwdata[RLDC_ON_BIT];
  wire [7:0] ctrl_unimpl = ref_ladder_control & ~RLDC_CTRL_WMASK;
  wire [7:0] level_unimpl = ref_ladder_level & ~RLDC_LEVEL_WMASK;

  property p_power_follows;
    1'b1 |=> (ladder_power == $past(f_on));
  endproperty
  a_power_follows: assert property (p_power_follows)
    else $error("ladder power does not follow converter_on");

  property p_tap_onehot;
    f_on |=> ($onehot(tap_select) && tap_select[$past(f_code)]);
  endproperty
  a_tap_onehot: assert property (p_tap_onehot)
    else $error("enabled ladder does not select the coded tap");

  property p_tap_off;
    !f_on |=> (tap_select == '0);
  endproperty
  a_tap_off: assert property (p_tap_off)
    else $error("tap selected while ladder is off");

  property p_clamp_pos;
    (!f_on && f_lpp && (f_code == RLDC_CODE_ONES))
      |=> (clamp_pos && pos_connect && !neg_connect && !clamp_neg);
  endproperty
  a_clamp_pos: assert property (p_clamp_pos)
    else $error("positive clamp not applied");

  property p_clamp_neg;
    (!f_on && !f_lpp && (f_code == RLDC_CODE_ZEROS))
      |=> (clamp_neg && neg_connect && !pos_connect && !clamp_pos);
  endproperty
  a_clamp_neg: assert property (p_clamp_neg)
    else $error("negative clamp not applied");

  property p_lp_open;
    !f_on |=> (neg_connect == !$past(f_lpp)) &&
      (pos_connect == $past(f_lpp));
  endproperty
  a_lp_open: assert property (p_lp_open)
    else $error("wrong ladder end opened in low-power state");

  property p_source;
    1'b1 |=> (source_select ==
      (($past(f_pss) == RLDC_PSS_SUPPLY) ? RLDC_SRC_SUPPLY :
       ($past(f_pss) == RLDC_PSS_EXTREF) ? RLDC_SRC_EXTREF :
       ($past(f_pss) == RLDC_PSS_FIXED) ? RLDC_SRC_FIXED :
       RLDC_SRC_NONE));
  endproperty
  a_source: assert property (p_source)
    else $error("positive source switch mismatch");

  property p_pin_override;
    f_pde |=> (pin_route_analog && pin_driver_off && pin_detector_off);
  endproperty
  a_pin_override: assert property (p_pin_override)
    else $error("pin not handed to the analog output");

  property p_pin_read_zero;
    pin_route_analog |-> !pin_read_value;
  endproperty
  a_pin_read_zero: assert property (p_pin_read_zero)
    else $error("digital read not zero while pin is analog");

  property p_pin_read_follows;
    !f_pde |=> (pin_read_value == $past(pin_sync));
  endproperty
  a_pin_read_follows: assert property (p_pin_read_follows)
    else $error("digital read does not follow the pin");

  property p_write_latency;
    dp_wr_ctrl |=> (f_on == $past(wd_on)) ##1
      (ladder_power == $past(wd_on, 2));
  endproperty
  a_write_latency: assert property (p_write_latency)
    else $error("control write not seen on outputs in time");

  property p_wake_hold;
    (wake_event && !dp_wr_ctrl) |=> $stable(ref_ladder_control);
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("control register changed on wake");

  property p_unimpl_zero;
    (ctrl_unimpl == 8'h00) && (level_unimpl == 8'h00);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented register bit is set");

  property p_read_back;
    (take_read && hit_ctrl) |=> (hrdata[7:0] == ref_ladder_control);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("control read returns wrong value");

  // Main scenarios
  c_enable_write: cover property (dp_wr_ctrl && wd_on ##2 ladder_power);
  c_clamp_pos: cover property (clamp_pos);
  c_clamp_neg: cover property (clamp_neg && !ladder_power);
  c_pin_route: cover property (pin_route_analog && pin_sync);
  c_top_tap: cover property (ladder_power && tap_select[RLDC_LEVELS-1]);

endmodule
`default_nettype wire

// >>> test/ladder_dac_control_bench.sv
// Self-checking bench: register access over AHB-Lite, switch drive
// checked through the ladder model. Single slave: hready = hreadyout.
`timescale 1ns/1ns
`default_nettype none
module ladder_dac_control_bench;
  import rldc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic wake_event = 1'b0, ext_level = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, source_select;
  logic hreadyout, hresp, ladder_power, clamp_pos, clamp_neg, pin_level;
  logic pos_connect, neg_connect, pin_route_analog, pin_driver_off;
  logic pin_detector_off, pin_read_value;
  logic [RLDC_LEVELS-1:0] tap_select;
  logic [5:0] vout;
  wire [10:0] sw = {ladder_power, clamp_pos, clamp_neg, pos_connect,
    neg_connect, source_select, pin_route_analog, pin_driver_off,
    pin_detector_off};
  int error_cnt = 0, n_tests = 0;

  always #10 hclk = ~hclk;

  rldc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_event(wake_event),
    .pin_level(pin_level), .ladder_power(ladder_power),
    .tap_select(tap_select), .clamp_pos(clamp_pos), .clamp_neg(clamp_neg),
    .pos_connect(pos_connect), .neg_connect(neg_connect),
    .source_select(source_select), .pin_route_analog(pin_route_analog),
    .pin_driver_off(pin_driver_off), .pin_detector_off(pin_detector_off),
    .pin_read_value(pin_read_value));

  rldc_ladder_model i_ladder (.ladder_power(ladder_power),
    .tap_select(tap_select), .clamp_pos(clamp_pos), .clamp_neg(clamp_neg),
    .ext_level(ext_level), .pin_level(pin_level), .vout_32ths(vout));

  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic give_verdict();
    $display("checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Called just after an edge; holds each phase until hready is seen
  task automatic bus(input logic wr, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
    chk(hresp, 1'b0);
  endtask

  // Outputs follow the register one edge after the write lands
  task automatic wr_settle(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge hclk);
    #1;
  endtask

  // ==========================================================
  // Watchdog: the tests need well under 1000 cycles
  initial
  begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    // Write lands at the data-phase edge, outputs one edge later
    bus(1'b1, 32'h0, 32'h88);
    #1;
    chk(ladder_power, 1'b0);
    @(posedge hclk);
    #1;
    chk(sw, 11'h4e0);
    for (int k = 0; k < 3; k++)
    begin
      wr_settle(32'h0, 32'h80 | (k << 2));
      chk(source_select, 3'h1 << k);
    end
    // Every tap of the ladder in turn
    for (int c = 0; c < 32; c++)
    begin
      wr_settle(32'h4, c);
      chk(tap_select, 32'h1 << c);
      chk(vout, c);
    end
    bus(1'b1, 32'h4, 32'hff);
    rd(32'h4, 32'h1f);
    // Source code 11 is never written by software
    bus(1'b1, 32'h0, 32'hf7);
    rd(32'h0, 32'he4);
    ext_level <= 1'b1;
    repeat (4) @(posedge hclk);
    #1;
    chk(sw[2:0], 3'h7);
    chk(pin_read_value, 1'b0);
    bus(1'b1, 32'h0, 32'hc4);
    repeat (4) @(posedge hclk);
    #1;
    chk(pin_read_value, 1'b1);
    // Low-power clamps; a near-clamp setting must not clamp
    bus(1'b1, 32'h0, 32'h40);
    wr_settle(32'h4, 32'h1f);
    chk(sw, 11'h288);
    chk(tap_select, 32'h0);
    chk(vout, 6'h20);
    wr_settle(32'h0, 32'h00);
    chk(sw, 11'h048);
    wr_settle(32'h4, 32'h00);
    chk(sw, 11'h148);
    // Reference off before sleep; wake pulses leave the register alone
    wr_settle(32'h0, 32'h28);
    wake_event <= 1'b1;
    repeat (3) @(posedge hclk);
    wake_event <= 1'b0;
    rd(32'h0, 32'h28);
    bus(1'b1, 32'h8, 32'hff);
    rd(32'h8, 32'h0);
    rd(32'h0, 32'h28);
    // Reset in mid-run, with the ladder powered and the pin routed
    bus(1'b1, 32'h0, 32'ha8);
    bus(1'b1, 32'h4, 32'h15);
    @(posedge hclk);
    #1;
    chk({ladder_power, pin_route_analog}, 2'h3);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk({ladder_power, pin_route_analog}, 2'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> test/rldc_ladder_model.sv
// Behavioural model of the analog ladder, its end switches and the pin.
// Assumes the switch controls of the block; reports output in 32nds.
`timescale 1ns/1ns
`default_nettype none
module rldc_ladder_model
  import rldc_pkg::*;
(
  input wire logic ladder_power, // Ladder bias on
  input wire logic [RLDC_LEVELS-1:0] tap_select, // One-hot tap
  input wire logic clamp_pos, // Tied to top source
  input wire logic clamp_neg, // Tied to bottom source
  input wire logic ext_level, // Level applied to the pad outside
  output logic pin_level, // Raw pad level seen by the block
  output logic [5:0] vout_32ths // Output in 32nds of the span
);
  // ==========================================================
  // Output voltage
  // A clamp wins over the tap; an unpowered, unclamped ladder floats
  // and is shown as the bottom source for simplicity.
  always_comb
  begin
    vout_32ths = 6'h00;
    if (clamp_pos)
      vout_32ths = 6'h20;
    else if (clamp_neg)
      vout_32ths = 6'h00;
    else if (ladder_power)
      for (int k = 0; k < RLDC_LEVELS; k++)
        if (tap_select[k])
          vout_32ths = 6'(k);
  end

  // Pad keeps showing the outside level even while routed to analog,
  // so the block alone must mask the digital read
  assign pin_level = ext_level;
endmodule
`default_nettype wire
